// *** rtl/pssc_pkg.sv ***
// Operation
// - Second waking: minimum dwell, then all enabled supplies good
// - Dwell field bits 20:16 gives two-power cycles
// - Each sleeping state lasts exactly its dwell
// - Awake register has no dwell; bits 31:15 reserved
// - Bit 14 stops the tile clock
// - Bit 9 selects analogue converter pulse-frequency mode
// - Bit 8 selects core converter pulse-frequency mode
// - Bit 5 enables the IO supply output
// - Bit 4 enables the PLL linear regulator
// - Bit 1 analogue converter enable, read-only one
// - Bit 0 enables the core converter
// - Second sleeping register resets analogue-only
// - State is a three-bit code, 0 to 7
package pssc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE2  = 8'h14;  // Second waking supply config.
  localparam logic [7:0] OFS_AWAKE  = 8'h18;  // Awake supply config.
  localparam logic [7:0] OFS_SLEEP1 = 8'h1c;  // First sleeping supply config.
  localparam logic [7:0] OFS_SLEEP2 = 8'h20;  // Second sleeping supply config.
  localparam logic [7:0] OFS_CTRL   = 8'h40;  // Sleep request control.
  localparam logic [7:0] OFS_STAT   = 8'h44;  // Sequencer status.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DWELL_LSB  = 16;  // Log2 dwell field, five bits.
  localparam int DWELL_W    = 5;   // Width of the dwell field.
  localparam int STATE_LSB  = 16;  // State code in the status register.
  localparam int B_CLKSTOP  = 14;  // Tile clock stop.
  localparam int B_ANA_PFM  = 9;   // Analogue converter modulation.
  localparam int B_CORE_PFM = 8;   // Core converter modulation.
  localparam int B_IO_EN    = 5;   // IO supply output enable.
  localparam int B_PLL_EN   = 4;   // PLL linear regulator enable.
  localparam int B_ANA_EN   = 1;   // Analogue converter enable.
  localparam int B_CORE_EN  = 0;   // Core converter enable.
  localparam int B_SLEEP    = 0;   // Sleep request in the control register.

  // ----------------------------------------------------------------
  // Write masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] WMASK_TIMED = 32'h001f_4331;  // Dwell plus settings.
  localparam logic [31:0] WMASK_AWAKE = 32'h0000_4331;  // Settings only.
  localparam logic [31:0] RO_ONES     = 32'h0000_0002;  // Analogue enable held at one.
  localparam logic [31:0] RST_WAKE2   = 32'h0010_0033;
  localparam logic [31:0] RST_AWAKE   = 32'h0000_0033;
  localparam logic [31:0] RST_SLEEP1  = 32'h0010_0022;
  localparam logic [31:0] RST_SLEEP2  = 32'h0010_0002;
  localparam logic [31:0] CFG_WAKE1   = 32'h0000_0022;  // Fixed first waking settings.
  localparam logic [31:0] CFG_ASLEEP  = 32'h0000_0002;  // Fixed asleep settings.

  // ----------------------------------------------------------------
  // Sequencer state codes and one-hot states
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_RESET  = 3'h0;
  localparam logic [2:0] CODE_ASLEEP = 3'h1;
  localparam logic [2:0] CODE_WAKE1  = 3'h2;
  localparam logic [2:0] CODE_WAKE2  = 3'h3;
  localparam logic [2:0] CODE_AWWAIT = 3'h4;
  localparam logic [2:0] CODE_AWAKE  = 3'h5;
  localparam logic [2:0] CODE_SLEEP1 = 3'h6;
  localparam logic [2:0] CODE_SLEEP2 = 3'h7;

  typedef enum logic [7:0] {
    ST_RESET  = 8'h01,
    ST_ASLEEP = 8'h02,
    ST_WAKE1  = 8'h04,
    ST_WAKE2  = 8'h08,
    ST_AWWAIT = 8'h10,
    ST_AWAKE  = 8'h20,
    ST_SLEEP1 = 8'h40,
    ST_SLEEP2 = 8'h80
  } pssc_state_t;

endpackage : pssc_pkg

// *** rtl/pssc_dwell_if.sv ***
// ------------------------------------------------------------------
// Link between the sequencer and its dwell timer
// ------------------------------------------------------------------
interface pssc_dwell_if;
  logic       restart;   // Restart counting from zero.
  logic [4:0] log2_len;  // Log2 of the dwell length in cycles.
  logic       expired;   // Last cycle of the dwell has been reached.

  modport tmr (input restart, input log2_len, output expired);
  modport seq (output restart, output log2_len, input expired);
endinterface : pssc_dwell_if

// *** rtl/pssc_dwell_timer.sv ***
// ------------------------------------------------------------------
// Dwell timer: counts cycles since state entry
// ------------------------------------------------------------------
module pssc_dwell_timer #(
  parameter int CNT_W = 32  // Counter width; field 31 needs 32 bits.
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Sequencer side
  pssc_dwell_if.tmr dw
);
  import pssc_pkg::*;

  if (CNT_W < 32) begin : g_chk
    $error("pssc_dwell_timer: CNT_W must be at least 32");
  end

  logic [CNT_W-1:0] cnt_r;    // Cycles spent in the current state.
  logic [CNT_W-1:0] cnt_nxt;  // Next count.
  logic [CNT_W-1:0] last;     // Count value of the final dwell cycle.

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  // The count saturates at the last cycle, and the compare is a
  // greater-or-equal so that shrinking the field mid-state cannot
  // make the timer run past its end and wrap.
  always_comb begin
    last    = (CNT_W'(1) << dw.log2_len) - CNT_W'(1);
    cnt_nxt = cnt_r;
    if (dw.restart) begin
      cnt_nxt = '0;
    end else if (cnt_r < last) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // A state of length 2**n leaves at the edge where the count is 2**n-1.
  assign dw.expired = (cnt_r >= last);

endmodule : pssc_dwell_timer

// *** rtl/pssc_seq.sv ***
// ------------------------------------------------------------------
// Power state supply configuration and sequencer
// ------------------------------------------------------------------
module pssc_seq (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Wake request and supply good reports
  input  wire logic        wake_i,
  input  wire logic        core_good_i,
  input  wire logic        analogue_good_i,
  input  wire logic        pll_good_i,
  input  wire logic        io_good_i,
  // Regulator and tile controls
  output logic             core_buck_converter_en_o,
  output logic             analogue_buck_converter_en_o,
  output logic             pll_linear_regulator_en_o,
  output logic             io_supply_output_en_o,
  output logic             core_buck_pfm_o,
  output logic             analogue_buck_pfm_o,
  output logic             tile_clk_stop_o,
  output logic [2:0]       seq_state_o
);
  import pssc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]  cfg_r   [4];  // Supply configs: wake2, awake, sleep1, sleep2.
  logic [31:0]  cfg_nxt [4];  // Next values of the configs.
  pssc_state_t  state_r;      // Current sequencer state.
  pssc_state_t  state_nxt;    // Next sequencer state.
  logic [31:0]  act_cfg;      // Settings of the state being entered.
  logic [31:0]  cur_cfg;      // Settings of the current state.
  logic [2:0]   code_nxt;     // Three-bit code of the next state.
  logic [6:0]   out_r;        // Registered control outputs.
  logic [6:0]   out_nxt;      // Next control outputs.
  logic [2:0]   code_r;       // Registered state code.
  logic         all_good;     // Every enabled supply reports good.
  logic         sleep_go;     // Accepted sleep request.
  logic         acc_phase;    // APB access phase, before the answer.
  logic         wr_take;      // Write takes effect at this edge.
  logic         rd_hit;       // Address is mapped.
  logic [31:0]  rd_data;      // Read multiplexer output.
  logic         pready_nxt;   // Next ready.
  logic [31:0]  prdata_nxt;   // Next read data.
  logic         pslverr_nxt;  // Next error flag.
  logic         pready_r;     // Ready flop.
  logic [31:0]  prdata_r;     // Read data flop.
  logic         pslverr_r;    // Error flop.

  pssc_dwell_if dw ();  // Link to the dwell timer.

  // ----------------------------------------------------------------
  // Dwell timer
  // ----------------------------------------------------------------
  pssc_dwell_timer #(
    .CNT_W (32)
  ) u_dwell (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .dw         (dw)
  );

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Every transfer takes one wait state: ready rises at the edge that ends
  // the first access cycle and the transfer completes at the following edge.
  // This keeps read data and the error flag straight from flip-flops.
  assign acc_phase = psel_i && penable_i && !pready_r;
  assign wr_take   = psel_i && penable_i && pready_r && pwrite_i;

  // Address decode and read multiplexer.
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr_i)
      OFS_WAKE2:  rd_data = cfg_r[0];
      OFS_AWAKE:  rd_data = cfg_r[1];
      OFS_SLEEP1: rd_data = cfg_r[2];
      OFS_SLEEP2: rd_data = cfg_r[3];
      OFS_CTRL:   rd_data = 32'h0000_0000;  // Request bit self-clears.
      OFS_STAT: begin
        // State code beside the settings now driven out.
        rd_data = 32'h0000_0000;
        rd_data[STATE_LSB +: 3] = code_r;
        rd_data[B_CLKSTOP]      = out_r[6];
        rd_data[B_ANA_PFM]      = out_r[5];
        rd_data[B_CORE_PFM]     = out_r[4];
        rd_data[B_IO_EN]        = out_r[3];
        rd_data[B_PLL_EN]       = out_r[2];
        rd_data[B_ANA_EN]       = out_r[1];
        rd_data[B_CORE_EN]      = out_r[0];
      end
      default: begin
        // Unmapped addresses answer with an error and zero data.
        rd_hit  = 1'b0;
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Next values of the bus answer flops.
  always_comb begin
    pready_nxt  = acc_phase;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (acc_phase) begin
      pslverr_nxt = !rd_hit;
      prdata_nxt  = pwrite_i ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Only writable bits are stored from the bus; reserved bits read
  // zero and the analogue enable is forced to one, so software can
  // never switch that converter off from here.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (wr_take) begin
      unique case (paddr_i)
        OFS_WAKE2:  cfg_nxt[0] = (pwdata_i & WMASK_TIMED) | RO_ONES;
        OFS_AWAKE:  cfg_nxt[1] = (pwdata_i & WMASK_AWAKE) | RO_ONES;
        OFS_SLEEP1: cfg_nxt[2] = (pwdata_i & WMASK_TIMED) | RO_ONES;
        OFS_SLEEP2: cfg_nxt[3] = (pwdata_i & WMASK_TIMED) | RO_ONES;
        default: begin
          // Other addresses leave the configs untouched.
          for (int i = 0; i < 4; i++) begin
            cfg_nxt[i] = cfg_r[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r[0] <= RST_WAKE2;
      cfg_r[1] <= RST_AWAKE;
      cfg_r[2] <= RST_SLEEP1;
      cfg_r[3] <= RST_SLEEP2;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // A sleep request counts only while awake; elsewhere it is dropped.
  assign sleep_go = wr_take && (paddr_i == OFS_CTRL) && pwdata_i[B_SLEEP]
                    && (state_r == ST_AWAKE);

  // Every supply that the current settings enable must report good.
  assign all_good = (!out_r[0] || core_good_i) && (!out_r[1] || analogue_good_i)
                    && (!out_r[2] || pll_good_i) && (!out_r[3] || io_good_i);

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET:  state_nxt = ST_WAKE1;
      ST_ASLEEP: begin
        if (wake_i) begin
          state_nxt = ST_WAKE1;
        end
      end
      ST_WAKE1: begin
        if (dw.expired && all_good) begin
          state_nxt = ST_WAKE2;
        end
      end
      ST_WAKE2: begin
        // Minimum dwell first, then wait on the supplies.
        if (dw.expired && all_good) begin
          state_nxt = ST_AWWAIT;
        end
      end
      ST_AWWAIT: begin
        if (all_good) begin
          state_nxt = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        if (sleep_go) begin
          state_nxt = ST_SLEEP1;
        end
      end
      ST_SLEEP1: begin
        if (dw.expired) begin
          state_nxt = ST_SLEEP2;
        end
      end
      ST_SLEEP2: begin
        if (dw.expired) begin
          state_nxt = ST_ASLEEP;
        end
      end
      default: state_nxt = ST_RESET;  // Recover from an illegal code.
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Timer restarts on every change of state.
  assign dw.restart = (state_nxt != state_r);

  // ----------------------------------------------------------------
  // Settings of a state
  // ----------------------------------------------------------------
  // Awake-wait runs on the awake settings so the supplies it waits
  // on are those that the awake state will keep.
  function automatic logic [31:0] cfg_of(input pssc_state_t s,
                                         input logic [31:0] c0,
                                         input logic [31:0] c1,
                                         input logic [31:0] c2,
                                         input logic [31:0] c3);
    logic [31:0] r;
    r = CFG_ASLEEP;
    unique case (s)
      ST_WAKE1:           r = CFG_WAKE1;
      ST_WAKE2:           r = c0;
      ST_AWWAIT, ST_AWAKE: r = c1;
      ST_SLEEP1:          r = c2;
      ST_SLEEP2:          r = c3;
      default:            r = CFG_ASLEEP;
    endcase
    return r;
  endfunction

  // Three-bit code of a state.
  function automatic logic [2:0] code_of(input pssc_state_t s);
    logic [2:0] r;
    r = CODE_RESET;
    unique case (s)
      ST_ASLEEP: r = CODE_ASLEEP;
      ST_WAKE1:  r = CODE_WAKE1;
      ST_WAKE2:  r = CODE_WAKE2;
      ST_AWWAIT: r = CODE_AWWAIT;
      ST_AWAKE:  r = CODE_AWAKE;
      ST_SLEEP1: r = CODE_SLEEP1;
      ST_SLEEP2: r = CODE_SLEEP2;
      default:   r = CODE_RESET;
    endcase
    return r;
  endfunction

  assign cur_cfg     = cfg_of(state_r, cfg_r[0], cfg_r[1], cfg_r[2], cfg_r[3]);
  assign dw.log2_len = cur_cfg[DWELL_LSB +: DWELL_W];

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Outputs follow the state being entered, so they change at the
  // same edge as the state; a write to the current state's register
  // shows at the same edge at which it is taken.
  always_comb begin
    act_cfg    = cfg_of(state_nxt, cfg_nxt[0], cfg_nxt[1], cfg_nxt[2], cfg_nxt[3]);
    code_nxt   = code_of(state_nxt);
    out_nxt[6] = act_cfg[B_CLKSTOP];
    out_nxt[5] = act_cfg[B_ANA_PFM];
    out_nxt[4] = act_cfg[B_CORE_PFM];
    out_nxt[3] = act_cfg[B_IO_EN];
    out_nxt[2] = act_cfg[B_PLL_EN];
    out_nxt[1] = act_cfg[B_ANA_EN];
    out_nxt[0] = act_cfg[B_CORE_EN];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_r  <= CFG_ASLEEP[6:0];
      code_r <= CODE_RESET;
    end else begin
      out_r  <= out_nxt;
      code_r <= code_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign prdata_o                     = prdata_r;
  assign pready_o                     = pready_r;
  assign pslverr_o                    = pslverr_r;
  assign tile_clk_stop_o              = out_r[6];
  assign analogue_buck_pfm_o          = out_r[5];
  assign core_buck_pfm_o              = out_r[4];
  assign io_supply_output_en_o        = out_r[3];
  assign pll_linear_regulator_en_o    = out_r[2];
  assign analogue_buck_converter_en_o = out_r[1];
  assign core_buck_converter_en_o     = out_r[0];
  assign seq_state_o                  = code_r;

endmodule : pssc_seq

// *** verif/pssc_supply_model.sv ***
// ----------------------------------------
// Supply regulators seen by the sequencer
// ----------------------------------------
module pssc_supply_model (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Enables in, order io, pll, analogue, core
  input  wire logic [3:0] en_i,
  input  wire logic [3:0] lag_i,
  // Good reports out, same order
  output logic [3:0]      good_o
);
  logic [3:0] ramp_r [4];  // Cycles since each enable rose.

  // A supply ramps for lag cycles; a disabled one reports bad at once, never stale good.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n_i || !en_i[i]) begin
        ramp_r[i] <= 4'h0;
      end else if (ramp_r[i] < lag_i) begin
        ramp_r[i] <= ramp_r[i] + 4'h1;
      end
    end
  end

  // Good only while enabled and ramped up.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      good_o[i] = en_i[i] && (ramp_r[i] >= lag_i);
    end
  end
endmodule // pssc_supply_model

// *** verif/pssc_seq_properties.sv ***
// ----------------------------------------
// Port checker for the supply sequencer
// ----------------------------------------
module pssc_seq_properties (
  // Clock, reset and inputs
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       wake_i,
  input wire logic       core_good_i,
  input wire logic       analogue_good_i,
  input wire logic       pll_good_i,
  input wire logic       io_good_i,
  // Design outputs
  input logic            pready_o,
  input logic            core_buck_converter_en_o,
  input logic            analogue_buck_converter_en_o,
  input logic            pll_linear_regulator_en_o,
  input logic            io_supply_output_en_o,
  input logic [2:0]      seq_state_o
);
  logic bad_sup;  // Some enabled supply is not yet good.

  // Gathered here so the waking check reads as one condition.
  assign bad_sup = (core_buck_converter_en_o && !core_good_i) ||
                   (analogue_buck_converter_en_o && !analogue_good_i) ||
                   (pll_linear_regulator_en_o && !pll_good_i) ||
                   (io_supply_output_en_o && !io_good_i);

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_wake2_hold: assert property (
    seq_state_o == 3'h3 && bad_sup |=> seq_state_o == 3'h3)
    else $error("second waking left with a supply not good");
  a_sleep1_next: assert property (
    seq_state_o == 3'h6 |=> seq_state_o inside {3'h6, 3'h7})
    else $error("first sleeping left to a wrong state");
  a_sleep2_next: assert property (
    seq_state_o == 3'h7 |=> seq_state_o inside {3'h7, 3'h1})
    else $error("second sleeping left to a wrong state");
  a_sleep_entry: assert property (
    seq_state_o == 3'h6 |-> $past(seq_state_o) inside {3'h5, 3'h6})
    else $error("first sleeping entered not from awake");
  a_asleep_hold: assert property (
    seq_state_o == 3'h1 && !wake_i |=> seq_state_o == 3'h1)
    else $error("asleep left without a wake request");
  a_ana_on: assert property (analogue_buck_converter_en_o)
    else $error("analogue converter enable dropped");
  a_asleep_quiet: assert property (seq_state_o == 3'h1 |->
    !core_buck_converter_en_o && !pll_linear_regulator_en_o && !io_supply_output_en_o)
    else $error("supply enabled while asleep");
  a_pready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait state");
  a_pready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
endmodule // pssc_seq_properties

bind pssc_seq pssc_seq_properties u_props (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
  .wake_i, .core_good_i, .analogue_good_i, .pll_good_i, .io_good_i, .pready_o,
  .core_buck_converter_en_o, .analogue_buck_converter_en_o, .pll_linear_regulator_en_o,
  .io_supply_output_en_o, .seq_state_o);

// *** verif/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pssc_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        wake    = 1'b0;
  logic        mon     = 1'b0;  // Output and dwell monitor armed.
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  lag     = 4'hc;  // Slow ramp first, so waking waits.
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tstop;
  logic        cpfm;
  logic        apfm;
  logic [2:0]  st;
  logic [2:0]  pst     = 3'h0;  // State seen at the previous edge.
  wire  [3:0]  en;              // Enables, one design port per bit.
  logic [3:0]  good;
  logic [31:0] sh [4];          // Shadow of the four config registers.
  logic [31:0] pc;
  logic [31:0] cc;              // Expected output pattern of the shown state.
  logic [31:0] os;              // Output pattern seen.
  logic [31:0] dwl;             // Dwell length of the state just left.
  logic [31:0] seed    = 32'h0000_96e3;
  int          len     = 0;
  int          cyc     = 0;
  int          miscompares = 0;
  int          n_checks    = 0;

  pssc_seq uut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .wake_i(wake), .core_good_i(good[0]),
    .analogue_good_i(good[1]), .pll_good_i(good[2]), .io_good_i(good[3]),
    .core_buck_converter_en_o(en[0]), .analogue_buck_converter_en_o(en[1]),
    .pll_linear_regulator_en_o(en[2]), .io_supply_output_en_o(en[3]),
    .core_buck_pfm_o(cpfm), .analogue_buck_pfm_o(apfm), .tile_clk_stop_o(tstop),
    .seq_state_o(st));

  pssc_supply_model u_sup (.core_clk_i(clk), .rst_n_i(rst_n), .en_i(en), .lag_i(lag),
    .good_o(good));

  // Clock of 8 ns.
  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Settings the outputs should show in a state.
  function automatic logic [31:0] cfg_of(input logic [2:0] s);
    case (s)
      3'h2:        return 32'h0000_0022;
      3'h3:        return sh[0];
      3'h4, 3'h5:  return sh[1];
      3'h6:        return sh[2];
      3'h7:        return sh[3];
      default:     return 32'h0000_0002;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; held until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (st !== s && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("state", {29'h0, s}, {29'h0, st});
  endtask

  // Outputs against the shadow each cycle; sleeping and second waking state lengths on leaving them.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
    if (rst_n === 1'b1) begin
      pc = cfg_of(pst);
      cc = cfg_of(st);
      cc = {25'h0, cc[14], cc[9:8], cc[5:4], cc[1:0]};
      os = {25'h0, tstop, apfm, cpfm, en};
      if (mon) chk("outputs", cc, os);
      if (st !== pst) begin
        dwl = 32'h1 << pc[20:16];
        if (mon && pst >= 3'h6) chk("dwell", dwl, 32'(len));
        if (mon && pst == 3'h3) chk("wake2_min", 32'h1, {31'h0, len >= dwl});
        len = 1;
      end else begin
        len++;
      end
      pst = st;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h14, 32'h0010_0033);
    rd(8'h18, 32'h0000_0033);
    rd(8'h1c, 32'h0010_0022);
    rd(8'h20, 32'h0010_0002);
    wr(8'h14, 32'h0000_0033);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h001f_4333);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0000_4333);
    wr(8'h18, 32'h0000_0000);
    rd(8'h18, 32'h0000_0002);
    apb(1'b0, 8'h28, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, q);
    wr(8'h1c, 32'h0000_0000);
    wr(8'h20, 32'h0000_0002);
    wr(8'h18, 32'h0000_0033);
    wait_st(3'h5);
    // Status shows the awake code beside the awake settings now driven.
    rd(8'h44, 32'h0005_0033);
    wr(8'h40, 32'h1);
    wait_st(3'h1);
    // Random settings with short dwells; configs change only while asleep.
    for (int k = 0; k < 12; k++) begin
      for (int i = 0; i < 4; i++) begin
        sh[i] = (xs() & ((i == 1) ? 32'h0000_4331 : 32'h0003_4331)) | 32'h2;
        wr(8'h14 + 8'(i * 4), sh[i]);
      end
      lag  <= 4'(xs() % 6);
      mon  <= 1'b1;
      wake <= 1'b1;
      wait_st(3'h5);
      wake <= 1'b0;
      wr(8'h40, 32'h1);
      wait_st(3'h1);
    end
    conclude();
  end
endmodule // tb_top
